// ===== pcr_eeprom_loader.sv
// serial eeprom reader for the subsystem identification word
`timescale 1ns/1ps
module pcr_eeprom_loader
  import pcr_pkg::*;
#(
  parameter int LOAD_MIN = LOAD_MIN_CYC,
  parameter int SK_HALF  = 16
)
(
  input  wire logic   ref_clk,
  input  wire logic   reset,
  input  wire logic   eeprom_data_in,
  output logic        eeprom_cs,
  output logic        eeprom_sk,
  output logic        eeprom_di,
  pcr_load_if.loader  ld
);
  localparam int CW = $clog2(LOAD_MIN + 1);
  localparam int DW = $clog2(SK_HALF + 1);
  localparam int WW = $clog2(START_WAIT_CYC + 1);
  if (SK_HALF < 1 || LOAD_MIN <= 2 * SK_HALF * EE_TOTAL_BITS + 2)
  begin : g_bad_timing
    $error("load time too short for the serial transfer");
  end
  pcr_load_state_type state_reg;
  logic [WW-1:0] wait_cnt_reg;
  logic [CW-1:0] total_cnt_reg;
  logic [DW-1:0] div_cnt_reg;
  logic [5:0]    bit_cnt_reg;
  logic [8:0]    cmd_reg;
  logic [31:0]   shift_reg;
  logic          sk_reg, cs_reg, di_reg, done_reg;
  logic          din_meta_reg, din_sync_reg;
  wire           tick = div_cnt_reg == DW'(SK_HALF - 1);
  wire           last = bit_cnt_reg == 6'(EE_TOTAL_BITS - 1);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg     <= LD_WAIT;
      wait_cnt_reg  <= '0;
      total_cnt_reg <= '0;
      div_cnt_reg   <= '0;
      bit_cnt_reg   <= 6'h00;
      cmd_reg       <= 9'h000;
      shift_reg     <= 32'h0000_0000;
      {sk_reg, cs_reg, di_reg, done_reg} <= 4'h0;
      {din_meta_reg, din_sync_reg}       <= 2'h0;
    end
    else
    begin
      din_meta_reg <= eeprom_data_in;
      din_sync_reg <= din_meta_reg;
      case (state_reg)
        LD_WAIT:
        begin
          wait_cnt_reg <= wait_cnt_reg + 1'b1;
          if (wait_cnt_reg == WW'(START_WAIT_CYC - 1))
          begin
            state_reg <= LD_SHIFT;
            cs_reg    <= 1'b1;
            cmd_reg   <= EE_CMD;
            di_reg    <= EE_CMD[8];
          end
        end
        LD_SHIFT:
        begin
          total_cnt_reg <= total_cnt_reg + 1'b1;
          div_cnt_reg   <= tick ? '0 : div_cnt_reg + 1'b1;
          if (tick && !sk_reg)
          begin
            sk_reg <= 1'b1;
            if (bit_cnt_reg >= 6'(EE_CMD_BITS))
              shift_reg <= {shift_reg[30:0], din_sync_reg};
          end
          else if (tick)
          begin
            sk_reg      <= 1'b0;
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            cmd_reg     <= {cmd_reg[7:0], 1'b0};
            di_reg      <= cmd_reg[7];
            if (last)
            begin
              cs_reg    <= 1'b0;
              state_reg <= LD_HOLD;
            end
          end
        end
        LD_HOLD:
        begin
          if (total_cnt_reg == CW'(LOAD_MIN - 1))
          begin
            done_reg  <= 1'b1;
            state_reg <= LD_DONE;
          end
          else
            total_cnt_reg <= total_cnt_reg + 1'b1;
        end
        default:
          state_reg <= LD_DONE;
      endcase
    end
  end
  assign eeprom_cs = cs_reg;
  assign eeprom_sk = sk_reg;
  assign eeprom_di = di_reg;
  assign ld.done   = done_reg;
  assign ld.data   = shift_reg;
  AST_LOAD_MIN_TIME: assert property (
    @(posedge ref_clk) disable iff (reset)
    $rose(done_reg) |-> total_cnt_reg == CW'(LOAD_MIN - 1))
    else $error("subsystem id ready before the least load time");
endmodule : pcr_eeprom_loader

// ===== pcr_eeprom_model.sv
// serial eeprom model answering the subsystem word read
`timescale 1ns/1ps
module pcr_eeprom_model
#(
  parameter logic [31:0] WORD = 32'hA5C3_1E7B  // arbitrary value
)
(
  input  wire logic       ref_clk,
  input  wire logic       cs,
  input  wire logic       sk,
  input  wire logic       di,
  output logic            dout,
  output logic      [8:0] cmd_seen
);
  logic       sk_reg;
  logic [5:0] bit_cnt;
  initial
  begin
    sk_reg = 1'b0;
    bit_cnt = 6'h00;
    dout = 1'b0;
    cmd_seen = 9'h000;
  end
  // released line toggles so a stale bit is never mistaken for data
  always @(posedge ref_clk)
  begin
    sk_reg <= sk;
    if (!cs)
    begin
      bit_cnt <= 6'h00;
      dout <= ~dout;
    end
    else if (sk && !sk_reg)
    begin
      bit_cnt <= bit_cnt + 6'h01;
      if (bit_cnt < 6'h09)
        cmd_seen <= {cmd_seen[7:0], di};
    end
    else if (!sk && sk_reg && bit_cnt >= 6'h09 && bit_cnt < 6'h29)
      dout <= WORD[6'h28 - bit_cnt];
  end
endmodule : pcr_eeprom_model

// ===== pcr_lane_reg.sv
// register with byte lane write enables and a writable bit mask
`timescale 1ns/1ps
module pcr_lane_reg
  import pcr_pkg::*;
#(
  parameter int           W    = 32,
  parameter logic [W-1:0] MASK = '1,
  parameter logic [W-1:0] RST  = '0
)
(
  input  wire logic           ref_clk,
  input  wire logic           reset,
  input  wire logic           wr_en,
  input  wire logic [W/8-1:0] lane_en,
  input  wire logic [W-1:0]   wdata,
  output logic      [W-1:0]   q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;
  logic [W-1:0] lane_bits;
  logic [W-1:0] wr_bits;
  if (W % 8 != 0)
  begin : g_bad_width
    $error("width must be whole bytes");
  end
  for (genvar i = 0; i < W / 8; i++)
  begin : g_lane
    assign lane_bits[i*8 +: 8] = {8{lane_en[i]}};
  end
  assign wr_bits = lane_bits & MASK;
  assign q_next  = wr_en ? ((wdata & wr_bits) | (q_reg & ~wr_bits)) : q_reg;
  assign q       = q_reg;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      q_reg <= RST;
    else
      q_reg <= q_next;
  end
endmodule : pcr_lane_reg

// ===== pcr_load_if.sv
// carrier for the eeprom loaded subsystem identification
`timescale 1ns/1ps
interface pcr_load_if;
  logic        done;
  logic [31:0] data;
  modport loader (output done, output data);
  modport user   (input done, input data);
endinterface : pcr_load_if

// ===== pcr_pci_target.sv
// pci target for configuration registers and the transmit dma control
`timescale 1ns/1ps
//
// Contract
// - base address bits 31..11 are writable and reset to zero
// - base register bits 10..1 always read zero
// - base register bit 0 reads zero, memory space indicator
// - eeprom load starts 50 pci cycles after reset, lasts 27400 or more
// - subsystem id access is retried until the load is done
// - subsystem id high half, subsystem vendor id low half
// - writes to subsystem id have no effect
// - bits 31..24 read bus access interval, reset 0x28
// - bits 23..16 read burst period length, reset 0x14
// - bits 15..8 read 0x01, first interrupt pin used
// - bits 7..0 hold the interrupt line, writable, reset 0x00
// - window registers are 32 bits, little endian lanes
// - window reads accept any byte enable pattern
// - window writes take byte, word or dword lanes, else target abort
// - unassigned window offsets are reserved
// - transmit control bits 29..24 cap words per dma burst
// - bit 18 enables udp checksum insertion
// - bit 17 enables tcp checksum insertion
// - bit 0 runs transmit dma, clearing stops after current frame
// - bit 1 enables crc append on each frame
module pcr_pci_target
  import pcr_pkg::*;
#(
  parameter int LOAD_MIN   = LOAD_MIN_CYC,
  parameter int EE_SK_HALF = 16
)
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        pci_frame_n,
  input  wire logic        pci_irdy_n,
  input  wire logic        pci_idsel,
  input  wire logic [31:0] pci_ad_in,
  input  wire logic [3:0]  pci_cbe_n,
  input  wire logic        mem_space_en,
  input  wire logic        tx_frame_active,
  input  wire logic        eeprom_data_in,
  output logic      [31:0] pci_ad_out,
  output logic             pci_ad_oe,
  output logic             pci_trdy_n,
  output logic             pci_devsel_n,
  output logic             pci_stop_n,
  output logic             pci_ctl_oe,
  output logic             eeprom_cs,
  output logic             eeprom_sk,
  output logic             eeprom_di,
  output logic             subsystem_ready,
  output logic      [5:0]  tx_burst_word_limit,
  output logic             tx_udp_checksum_insert,
  output logic             tx_tcp_checksum_insert,
  output logic             tx_crc_append,
  output logic             tx_dma_run,
  output logic             tx_dma_active,
  output logic      [7:0]  interrupt_line
);
  pcr_tgt_state_type state_reg;
  pcr_tgt_state_type state_next;
  logic [31:0] addr_reg;
  logic [3:0]  cmd_reg;
  logic [31:0] ad_out_reg;
  logic        ad_oe_reg;
  logic        trdy_n_reg;
  logic        devsel_n_reg;
  logic        stop_n_reg;
  logic        ctl_oe_reg;
  logic        active_reg;
  logic [31:0] base_q;
  logic [31:0] int_q;
  logic [31:0] tx_q;
  logic [31:0] rdata;
  logic [3:0]  byte_lane_enables;
  pcr_load_if  ld ();

  pcr_eeprom_loader #(
    .LOAD_MIN (LOAD_MIN),
    .SK_HALF  (EE_SK_HALF)
  ) u_loader (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .eeprom_data_in (eeprom_data_in),
    .eeprom_cs      (eeprom_cs),
    .eeprom_sk      (eeprom_sk),
    .eeprom_di      (eeprom_di),
    .ld             (ld.loader)
  );

  // address phase decode
  wire addr_phase = state_reg == ST_IDLE && !pci_frame_n;
  wire cmd_cfg_in = pci_cbe_n == CMD_CFG_RD || pci_cbe_n == CMD_CFG_WR;
  wire cmd_mem_in = pci_cbe_n == CMD_MEM_RD || pci_cbe_n == CMD_MEM_WR;
  wire base_hit   = pci_ad_in[31:BASE_LSB] == base_q[31:BASE_LSB];
  wire cfg_claim  = pci_idsel && cmd_cfg_in && pci_ad_in[1:0] == 2'b00;
  wire mem_claim  = mem_space_en && cmd_mem_in && base_hit;
  wire claim      = addr_phase && (cfg_claim || mem_claim);

  // data phase decode
  wire data_phase = state_reg == ST_WAIT && !pci_irdy_n;
  wire is_cfg     = cmd_reg == CMD_CFG_RD || cmd_reg == CMD_CFG_WR;
  wire is_write   = cmd_reg == CMD_CFG_WR || cmd_reg == CMD_MEM_WR;
  assign byte_lane_enables = ~pci_cbe_n;
  wire be_byte  = byte_lane_enables == 4'h1 || byte_lane_enables == 4'h2 ||
                  byte_lane_enables == 4'h4 || byte_lane_enables == 4'h8;
  wire be_word  = byte_lane_enables == 4'h3 || byte_lane_enables == 4'hC;
  wire be_dword = byte_lane_enables == 4'hF;
  wire be_legal = be_byte || be_word || be_dword;

  wire sel_base   = is_cfg && addr_reg[7:0] == OFF_MEM_BASE;
  wire sel_subsys = is_cfg && addr_reg[7:0] == OFF_SUBSYS_ID;
  wire sel_int    = is_cfg && addr_reg[7:0] == OFF_INT_CFG;
  wire sel_tx     = !is_cfg && {addr_reg[10:2], 2'b00} == CSR_OFF_TX_CTRL;

  wire do_retry = data_phase && sel_subsys && !ld.done;
  wire do_abort = data_phase && !is_cfg && is_write && !be_legal;
  wire do_xfer  = data_phase && !do_retry && !do_abort;
  wire do_read  = do_xfer && !is_write;
  wire base_we  = do_xfer && is_write && sel_base;
  wire int_we   = do_xfer && is_write && sel_int;
  wire tx_we    = do_xfer && is_write && sel_tx;

  // unassigned offsets read zero and ignore writes
  assign rdata = sel_base   ? (base_q & BASE_MASK) :
                 sel_subsys ? ld.data :
                 sel_int    ? int_q :
                 sel_tx     ? (tx_q & TX_CTRL_MASK) :
                 32'h0000_0000;

  pcr_lane_reg #(
    .W    (32),
    .MASK (BASE_MASK),
    .RST  (BASE_RESET)
  ) u_base (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (base_we),
    .lane_en (byte_lane_enables),
    .wdata   (pci_ad_in),
    .q       (base_q)
  );

  pcr_lane_reg #(
    .W    (32),
    .MASK (INT_CFG_MASK),
    .RST  (INT_CFG_RESET)
  ) u_int_cfg (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (int_we),
    .lane_en (byte_lane_enables),
    .wdata   (pci_ad_in),
    .q       (int_q)
  );

  pcr_lane_reg #(
    .W    (32),
    .MASK (TX_CTRL_MASK),
    .RST  (TX_CTRL_RESET)
  ) u_tx_ctrl (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (tx_we),
    .lane_en (byte_lane_enables),
    .wdata   (pci_ad_in),
    .q       (tx_q)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (claim)
          state_next = ST_WAIT;
      ST_WAIT:
        if (data_phase)
          state_next = ST_RESP;
      ST_RESP:
        state_next = ST_TURN;
      default:
        state_next = ST_IDLE;
    endcase
  end

  wire devsel_n_next = !(state_next == ST_WAIT || (data_phase && !do_abort));
  // disconnect with data when the master tries to burst
  wire stop_n_next   = !(do_retry || do_abort || (do_xfer && !pci_frame_n));
  wire [31:0] ad_next = do_read ? rdata : ad_out_reg;
  wire tx_run_bit    = tx_q[TX_RUN_BIT];
  wire active_next   = tx_run_bit || (active_reg && tx_frame_active);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_reg    <= ST_IDLE;
      addr_reg     <= 32'h0000_0000;
      cmd_reg      <= 4'h0;
      ad_out_reg   <= 32'h0000_0000;
      ad_oe_reg    <= 1'b0;
      trdy_n_reg   <= 1'b1;
      devsel_n_reg <= 1'b1;
      stop_n_reg   <= 1'b1;
      ctl_oe_reg   <= 1'b0;
      active_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (claim)
      begin
        addr_reg <= pci_ad_in;
        cmd_reg  <= pci_cbe_n;
      end
      ad_out_reg   <= ad_next;
      ad_oe_reg    <= do_read;
      trdy_n_reg   <= !do_xfer;
      devsel_n_reg <= devsel_n_next;
      stop_n_reg   <= stop_n_next;
      ctl_oe_reg   <= state_next != ST_IDLE;
      active_reg   <= active_next;
    end
  end

  assign pci_ad_out   = ad_out_reg;
  assign pci_ad_oe    = ad_oe_reg;
  assign pci_trdy_n   = trdy_n_reg;
  assign pci_devsel_n = devsel_n_reg;
  assign pci_stop_n   = stop_n_reg;
  assign pci_ctl_oe   = ctl_oe_reg;
  assign subsystem_ready        = ld.done;
  assign tx_burst_word_limit    = tx_q[TX_BURST_MSB:TX_BURST_LSB];
  assign tx_udp_checksum_insert = tx_q[TX_UDP_BIT];
  assign tx_tcp_checksum_insert = tx_q[TX_TCP_BIT];
  assign tx_crc_append          = tx_q[TX_CRC_BIT];
  assign tx_dma_run             = tx_run_bit;
  assign tx_dma_active          = active_reg;
  assign interrupt_line         = int_q[7:0];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  AST_BASE_LOW_ZERO: assert property (
    (data_phase && sel_base && !is_write) ##1 1'b1
    |-> pci_ad_out[10:0] == 11'h000 && !pci_trdy_n)
    else $error("base register low bits not zero on read");
  AST_SUBSYS_RETRY: assert property (
    (data_phase && sel_subsys && !ld.done)
    |=> !pci_stop_n && pci_trdy_n && !pci_devsel_n)
    else $error("subsystem id access not retried before load");
  AST_SUBSYS_STABLE: assert property (
    ld.done && $past(ld.done) |-> $stable(ld.data))
    else $error("subsystem id changed after load");
  AST_BAD_LANES_ABORT: assert property (
    (data_phase && !is_cfg && is_write && !be_legal)
    |=> pci_devsel_n && !pci_stop_n && pci_trdy_n ##1 pci_stop_n)
    else $error("illegal write lanes not target aborted");
  AST_INT_FIXED: assert property (
    int_q[31:8] == INT_CFG_FIXED)
    else $error("interrupt config fixed fields changed");
  AST_NO_CLAIM: assert property (
    (addr_phase && !cfg_claim && !(mem_space_en && base_hit))
    |=> pci_devsel_n [*2])
    else $error("memory cycle claimed without enable or base match");
  AST_TX_STOP: assert property (
    (tx_dma_active && !tx_dma_run && !tx_frame_active) |=> !tx_dma_active)
    else $error("transmit dma did not stop after its frame");
  AST_TX_RESERVED: assert property (
    (tx_q & ~TX_CTRL_MASK) == 32'h0000_0000)
    else $error("reserved transmit control bits set");
  AST_READ_ANY_LANES: assert property (
    (data_phase && !is_write && !do_retry)
    |=> !pci_trdy_n && pci_ad_oe ##1 pci_trdy_n)
    else $error("read not completed in one data cycle");
  AST_CLAIM_DEVSEL: assert property (
    claim |=> !pci_devsel_n && pci_ctl_oe && pci_trdy_n)
    else $error("claimed cycle did not assert devsel");
  AST_BASE_WRITE: assert property (
    (base_we && byte_lane_enables == 4'hF)
    |=> (base_q & BASE_MASK) == ($past(pci_ad_in) & BASE_MASK))
    else $error("base address write did not land");
  AST_INT_LINE_WRITE: assert property (
    (int_we && byte_lane_enables[0])
    |=> {24'h00_0000, interrupt_line} == ($past(pci_ad_in) & INT_CFG_MASK))
    else $error("interrupt line write did not land");
  AST_SUBSYS_READ: assert property (
    (do_read && sel_subsys) |=> pci_ad_out == $past(ld.data))
    else $error("subsystem id read data wrong");
  AST_RESERVED_READ: assert property (
    (do_read && !is_cfg && !sel_tx) |=> pci_ad_out == 32'h0000_0000)
    else $error("reserved window offset read not zero");

  COV_READ_DONE: cover property (data_phase && !is_write ##1 !pci_trdy_n);
  COV_RETRY: cover property (do_retry);
  COV_ABORT: cover property (do_abort);
  COV_TX_WRITE: cover property (tx_we ##1 tx_dma_run);
  COV_LOAD_DONE: cover property ($rose(subsystem_ready));
endmodule : pcr_pci_target

// ===== pcr_pci_target_tb_top.sv
// self-checking bench for the pci target register block
`timescale 1ns/1ps
module pcr_pci_target_tb_top
  import pcr_pkg::*;
;
  localparam int          LMIN    = 3000;
  localparam int          SKH     = 4;
  localparam logic [31:0] EE_WORD = 32'hA5C3_1E7B;  // arbitrary value
  localparam logic [31:0] BASE    = 32'h1234_5800;
  localparam logic [1:0]  R_OK    = 2'h0;
  localparam logic [1:0]  R_RETRY = 2'h1;
  localparam logic [1:0]  R_ABORT = 2'h2;
  localparam logic [1:0]  R_NONE  = 2'h3;
  logic        ref_clk, reset, frame_n, irdy_n, idsel, mem_en, frame_act;
  logic [31:0] host_ad, ad_out, rd;
  logic [3:0]  cbe_n;
  logic        ad_oe, trdy_n, devsel_n, stop_n, ctl_oe;
  logic        ee_cs, ee_sk, ee_di, ee_do, ready, udp, tcp, crc, run, act;
  logic [5:0]  burst;
  logic [7:0]  int_line;
  logic [8:0]  cmd_seen;
  logic [1:0]  rsp;
  int          bad_count, tests_run, cyc, cs_cyc, rdy_cyc;
  wire  [31:0] ad_wire = ad_oe ? ad_out : host_ad;

  pcr_pci_target #(.LOAD_MIN(LMIN), .EE_SK_HALF(SKH)) dut_u (
    .ref_clk(ref_clk), .reset(reset), .pci_frame_n(frame_n),
    .pci_irdy_n(irdy_n), .pci_idsel(idsel), .pci_ad_in(ad_wire),
    .pci_cbe_n(cbe_n), .mem_space_en(mem_en),
    .tx_frame_active(frame_act), .eeprom_data_in(ee_do),
    .pci_ad_out(ad_out), .pci_ad_oe(ad_oe), .pci_trdy_n(trdy_n),
    .pci_devsel_n(devsel_n), .pci_stop_n(stop_n), .pci_ctl_oe(ctl_oe),
    .eeprom_cs(ee_cs), .eeprom_sk(ee_sk), .eeprom_di(ee_di),
    .subsystem_ready(ready), .tx_burst_word_limit(burst),
    .tx_udp_checksum_insert(udp), .tx_tcp_checksum_insert(tcp),
    .tx_crc_append(crc), .tx_dma_run(run), .tx_dma_active(act),
    .interrupt_line(int_line));

  pcr_eeprom_model #(.WORD(EE_WORD)) ee_u (
    .ref_clk(ref_clk), .cs(ee_cs), .sk(ee_sk), .di(ee_di),
    .dout(ee_do), .cmd_seen(cmd_seen));

  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
  begin
    cyc <= reset ? 0 : cyc + 1;
    if (ee_cs && cs_cyc < 0)
      cs_cyc <= cyc;
    if (ready && rdy_cyc < 0)
      rdy_cyc <= cyc;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_rsp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_rsp

  // single data phase; irdy held until the edge that sees trdy or stop
  task automatic acc(input logic [3:0] cmd, input logic [31:0] addr,
      input logic [3:0] lanes_n, input logic [31:0] wd,
      input logic [1:0] er);
    int i;
    rsp = R_NONE;
    rd = 32'h0000_0000;
    @(posedge ref_clk);
    #1;
    frame_n = 1'b0;
    idsel = cmd[3];
    host_ad = addr;
    cbe_n = cmd;
    @(posedge ref_clk);
    #1;
    frame_n = 1'b1;
    irdy_n = 1'b0;
    idsel = 1'b0;
    cbe_n = lanes_n;
    host_ad = cmd[0] ? wd : ~addr;
    for (i = 0; i < 8 && rsp == R_NONE; i++)
    begin
      @(negedge ref_clk);
      if (!trdy_n)
        rsp = R_OK;
      else if (!stop_n)
        rsp = devsel_n ? R_ABORT : R_RETRY;
      rd = ad_wire;
    end
    @(posedge ref_clk);
    #1;
    irdy_n = 1'b1;
    cbe_n = 4'hF;
    host_ad = ~host_ad;
    repeat (4) @(posedge ref_clk);
    #1;
    chk_rsp(rsp, er);
  endtask : acc

  task automatic t_reset_vals;
    chk_val({7'h00, ctl_oe, ad_oe, trdy_n, devsel_n, stop_n, ready, run,
      act, crc, udp, tcp, burst, int_line}, 32'h0070_0000);
    acc(CMD_CFG_RD, 32'h0000_0010, 4'h0, 32'h0, R_OK);
    chk_val(rd, BASE_RESET);
    acc(CMD_CFG_RD, 32'h0000_003C, 4'h0, 32'h0, R_OK);
    chk_val(rd, 32'h2814_0100);
    acc(CMD_CFG_RD, 32'h0000_002C, 4'h0, 32'h0, R_RETRY);
    acc(CMD_CFG_WR, 32'h0000_002C, 4'h0, 32'h0, R_RETRY);
  endtask : t_reset_vals

  task automatic t_cfg_regs;
    acc(CMD_CFG_WR, 32'h0000_0010, 4'h0, 32'hFFFF_FFFF, R_OK);
    acc(CMD_CFG_RD, 32'h0000_0010, 4'h0, 32'h0, R_OK);
    chk_val(rd, 32'hFFFF_F800);
    acc(CMD_CFG_WR, 32'h0000_0010, 4'h0, BASE | 32'h7FF, R_OK);
    acc(CMD_CFG_RD, 32'h0000_0010, 4'h0, 32'h0, R_OK);
    chk_val(rd, BASE);
    acc(CMD_CFG_WR, 32'h0000_003C, 4'h0, 32'hFFFF_FF5A, R_OK);
    acc(CMD_CFG_RD, 32'h0000_003C, 4'h0, 32'h0, R_OK);
    chk_val(rd, 32'h2814_015A);
    chk_val({24'h0, int_line}, 32'h0000_005A);
  endtask : t_cfg_regs

  task automatic t_csr_access;
    int e;
    acc(CMD_MEM_RD, BASE, 4'h0, 32'h0, R_NONE);
    mem_en = 1'b1;
    acc(CMD_MEM_RD, BASE ^ 32'h0000_0800, 4'h0, 32'h0, R_NONE);
    for (e = 1; e < 16; e++)
      acc(CMD_MEM_WR, BASE | 32'h8, ~e[3:0], 32'hFFFF_FFFF,
        (e inside {1, 2, 3, 4, 8, 12, 15}) ? R_OK : R_ABORT);
    acc(CMD_MEM_RD, BASE | 32'h8, 4'h0, 32'h0, R_OK);
    chk_val(rd, 32'h0000_0000);
    acc(CMD_MEM_WR, BASE, 4'h0, 32'hFFFF_FFFF, R_OK);
    acc(CMD_MEM_RD, BASE, 4'hA, 32'h0, R_OK);
    chk_val(rd, 32'h3F06_0003);
    chk_val({26'h0, burst}, 32'h0000_003F);
    chk_val({31'h0, udp}, 32'h0000_0001);
    chk_val({31'h0, tcp}, 32'h0000_0001);
    chk_val({31'h0, crc}, 32'h0000_0001);
    acc(CMD_MEM_WR, BASE, 4'h7, 32'h0000_0000, R_OK);
    acc(CMD_MEM_WR, BASE, 4'hA, 32'h0000_0000, R_ABORT);
    acc(CMD_MEM_RD, BASE, 4'h0, 32'h0, R_OK);
    chk_val(rd, 32'h0006_0003);
  endtask : t_csr_access

  task automatic t_dma_run;
    acc(CMD_MEM_WR, BASE, 4'h0, 32'h0000_0000, R_OK);
    chk_val({31'h0, act}, 32'h0000_0000);
    frame_act = 1'b1;
    acc(CMD_MEM_WR, BASE, 4'h0, 32'h0000_0001, R_OK);
    chk_val({30'h0, run, act}, 32'h0000_0003);
    acc(CMD_MEM_WR, BASE, 4'h0, 32'h0000_0000, R_OK);
    chk_val({30'h0, run, act}, 32'h0000_0001);
    frame_act = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk_val({31'h0, act}, 32'h0000_0000);
  endtask : t_dma_run

  task automatic t_load;
    int i;
    for (i = 0; i < 6000 && ready !== 1'b1; i++)
      @(posedge ref_clk);
    #1;
    chk_val({31'h0, ready}, 32'h0000_0001);
    chk_val({31'h0, cs_cyc >= START_WAIT_CYC &&
      cs_cyc <= START_WAIT_CYC + 4}, 32'h0000_0001);
    chk_val({31'h0, rdy_cyc >= LMIN + START_WAIT_CYC &&
      rdy_cyc <= LMIN + START_WAIT_CYC + 8}, 32'h0000_0001);
    chk_val({23'h0, cmd_seen}, {23'h0, EE_CMD});
    acc(CMD_CFG_RD, 32'h0000_002C, 4'h0, 32'h0, R_OK);
    chk_val(rd, EE_WORD);
    acc(CMD_CFG_WR, 32'h0000_002C, 4'h0, 32'h0, R_OK);
    acc(CMD_CFG_RD, 32'h0000_002C, 4'h0, 32'h0, R_OK);
    chk_val(rd, EE_WORD);
  endtask : t_load

  initial
  begin
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    cs_cyc = -1;
    rdy_cyc = -1;
    reset = 1'b1;
    frame_n = 1'b1;
    irdy_n = 1'b1;
    idsel = 1'b0;
    host_ad = 32'h0000_0000;
    cbe_n = 4'hF;
    mem_en = 1'b0;
    frame_act = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    t_reset_vals();
    t_cfg_regs();
    t_csr_access();
    t_dma_run();
    t_load();
    tally_and_finish();
  end
endmodule : pcr_pci_target_tb_top

// ===== pcr_pkg.sv
// constants and types for the pci target register block
package pcr_pkg;
  localparam logic [3:0]  CMD_CFG_RD      = 4'hA;
  localparam logic [3:0]  CMD_CFG_WR      = 4'hB;
  localparam logic [3:0]  CMD_MEM_RD      = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR      = 4'h7;
  localparam logic [7:0]  OFF_MEM_BASE    = 8'h10;
  localparam logic [7:0]  OFF_SUBSYS_ID   = 8'h2C;
  localparam logic [7:0]  OFF_INT_CFG     = 8'h3C;
  localparam logic [10:0] CSR_OFF_TX_CTRL = 11'h000;
  localparam int          BASE_LSB        = 11;
  localparam logic [31:0] BASE_MASK       = 32'hFFFF_F800;
  localparam logic [31:0] BASE_RESET      = 32'h0000_0000;
  localparam logic [31:0] INT_CFG_MASK    = 32'h0000_00FF;
  localparam logic [31:0] INT_CFG_RESET   = 32'h2814_0100;
  localparam logic [23:0] INT_CFG_FIXED   = 24'h28_1401;
  localparam logic [31:0] TX_CTRL_MASK    = 32'h3F06_0003;
  localparam logic [31:0] TX_CTRL_RESET   = 32'h0000_0000;
  localparam int          TX_BURST_LSB    = 24;
  localparam int          TX_BURST_MSB    = 29;
  localparam int          TX_UDP_BIT      = 18;
  localparam int          TX_TCP_BIT      = 17;
  localparam int          TX_CRC_BIT      = 1;
  localparam int          TX_RUN_BIT      = 0;
  // pci bus cycles converted to ref_clk cycles, rounded up
  localparam int          PCI_PERIOD_PS   = 30303;
  localparam int          REF_PERIOD_PS   = 5000;
  localparam int          START_WAIT_PCI  = 50;
  localparam int          LOAD_MIN_PCI    = 27400;
  localparam int          START_WAIT_CYC  =
    (START_WAIT_PCI * PCI_PERIOD_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
  localparam int          LOAD_MIN_CYC    =
    (LOAD_MIN_PCI * PCI_PERIOD_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
  localparam logic [8:0]  EE_CMD          = 9'h180;
  localparam int          EE_CMD_BITS     = 9;
  localparam int          EE_TOTAL_BITS   = 41;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RESP, ST_TURN}
    pcr_tgt_state_type;
  typedef enum logic [1:0] {LD_WAIT, LD_SHIFT, LD_HOLD, LD_DONE}
    pcr_load_state_type;
endpackage : pcr_pkg
